// *** design/itb_pkg.sv ***
package itb_pkg;

    // Register addresses on the special-function-register port
    localparam logic [7:0] ADDR_CTRL   = 8'ha1;
    localparam logic [7:0] ADDR_FRAC   = 8'ha2;
    localparam logic [7:0] ADDR_SEC    = 8'ha3;
    localparam logic [7:0] ADDR_MIN    = 8'ha4;
    localparam logic [7:0] ADDR_HOUR   = 8'ha5;
    localparam logic [7:0] ADDR_TARGET = 8'ha6;

    // Values after reset
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [1:0] RESET_TBSEL = 2'h0;

    // Field positions in interval_timer_control
    localparam int CTRL_TIME_EN   = 0;
    localparam int CTRL_IV_EN     = 1;
    localparam int CTRL_FLAG      = 2;
    localparam int CTRL_SINGLE    = 3;
    localparam int CTRL_TBSEL_LO  = 4;
    localparam int CTRL_TBSEL_HI  = 5;

    // Terminal counts of the time registers
    localparam logic [7:0] FRAC_MAX = 8'h7f;
    localparam logic [7:0] SEC_MAX  = 8'h3b;
    localparam logic [7:0] MIN_MAX  = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;

    // Base tick of 1/128 s at a 5 ns clock
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_TIME_NS  = 7812500;
    localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int          TICK_CNT_W    = 21;

    // Timebase that clocks the interval counter
    typedef enum logic [1:0] {
        TB_FRAC = 2'h0,
        TB_SEC  = 2'h1,
        TB_MIN  = 2'h2,
        TB_HOUR = 2'h3
    } itb_tbase_t;

endpackage : itb_pkg

// *** design/itb_tick_if.sv ***
`timescale 1ns/1ps
interface itb_tick_if;
    logic run;
    logic tick;
    modport gen  (input run, output tick);
    modport user (output run, input tick);
endinterface : itb_tick_if

// *** design/itb_tick_gen.sv ***
`timescale 1ns/1ps
module itb_tick_gen #(
    parameter int unsigned TICK_CYCLES = itb_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Tick link to the time registers
    itb_tick_if.gen  tb
);

    logic [itb_pkg::TICK_CNT_W-1:0] cnt_r;
    wire                            atEnd;

    assign atEnd = (cnt_r == itb_pkg::TICK_CNT_W'(TICK_CYCLES - 1));

    // Prescaler restarts whenever the time clock is stopped, so a fresh start
    // always gives a full first period
    always_ff @(posedge core_clk) begin
        if (sys_rst || !tb.run) begin
            cnt_r   <= '0;
            tb.tick <= 1'b0;
        end else begin
            cnt_r   <= atEnd ? '0 : cnt_r + 1'b1;
            tb.tick <= atEnd;
        end
    end

endmodule : itb_tick_gen

// *** design/itb_timebase.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Interval counter stepping up to target sets match flag; interrupt gating is outside.
// - Fraction count advances every 1/128 s while time clock enabled, else holds.
// - Fraction counts 0..127, wraps to 0 and bumps seconds.
// - Seconds count 0..59, wrap to 0 and bump minutes.
// - Minutes count 0..59, wrap to 0 and bump hours.
// - Hours count 0..23, wrap to 0, no further carry.
// - Two-bit select picks which rollover clocks the interval counter.
// - Single mode: match clears interval enable; otherwise counter reloads and runs.
// - Clearing interval enable stops and zeroes the interval counter.
// - Clearing time enable clears time registers; they are writable only while low.
module itb_timebase #(
    parameter int unsigned TICK_CYCLES = itb_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Special-function-register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    output logic      [7:0] sfrRdData,
    // Status toward the interrupt controller
    output logic            matchFlag
);

    // Control and time state
    logic                 timeEn_r, ivEn_r, flag_r, single_r;
    itb_pkg::itb_tbase_t  tbSel_r;
    logic [7:0]           frac_r, sec_r, min_r, hour_r, target_r, ivCnt_r, rd_r;

    itb_tick_if tickLink ();

    itb_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tb       (tickLink.gen)
    );

    assign tickLink.run = timeEn_r;

    // Register write decode
    wire wrCtrl   = sfrWrEn && (sfrAddr == itb_pkg::ADDR_CTRL);
    wire wrTarget = sfrWrEn && (sfrAddr == itb_pkg::ADDR_TARGET);
    wire wrFrac   = sfrWrEn && (sfrAddr == itb_pkg::ADDR_FRAC) && !timeEn_r;
    wire wrSec    = sfrWrEn && (sfrAddr == itb_pkg::ADDR_SEC) && !timeEn_r;
    wire wrMin    = sfrWrEn && (sfrAddr == itb_pkg::ADDR_MIN) && !timeEn_r;
    wire wrHour   = sfrWrEn && (sfrAddr == itb_pkg::ADDR_HOUR) && !timeEn_r;
    wire timeStop = wrCtrl && timeEn_r && !sfrWrData[itb_pkg::CTRL_TIME_EN];

    // Cascade of rollovers; a tick that lingers past a stop is dropped
    wire tick     = tickLink.tick && timeEn_r;
    wire fracWrap = tick && (frac_r == itb_pkg::FRAC_MAX);
    wire secWrap  = fracWrap && (sec_r == itb_pkg::SEC_MAX);
    wire minWrap  = secWrap && (min_r == itb_pkg::MIN_MAX);
    wire hourWrap = minWrap && (hour_r == itb_pkg::HOUR_MAX);

    // Next values of the time registers; a stop outranks everything
    wire [7:0] frac_nxt = timeStop ? itb_pkg::RESET_BYTE :
                          wrFrac   ? sfrWrData :
                          fracWrap ? itb_pkg::RESET_BYTE :
                          tick     ? frac_r + 8'h01 : frac_r;
    wire [7:0] sec_nxt  = timeStop ? itb_pkg::RESET_BYTE :
                          wrSec    ? sfrWrData :
                          secWrap  ? itb_pkg::RESET_BYTE :
                          fracWrap ? sec_r + 8'h01 : sec_r;
    wire [7:0] min_nxt  = timeStop ? itb_pkg::RESET_BYTE :
                          wrMin    ? sfrWrData :
                          minWrap  ? itb_pkg::RESET_BYTE :
                          secWrap  ? min_r + 8'h01 : min_r;
    wire [7:0] hour_nxt = timeStop ? itb_pkg::RESET_BYTE :
                          wrHour   ? sfrWrData :
                          hourWrap ? itb_pkg::RESET_BYTE :
                          minWrap  ? hour_r + 8'h01 : hour_r;

    // Timebase selection for the interval counter
    wire selEvent = (tbSel_r == itb_pkg::TB_FRAC) ? tick :
                    (tbSel_r == itb_pkg::TB_SEC)  ? fracWrap :
                    (tbSel_r == itb_pkg::TB_MIN)  ? secWrap : minWrap;
    wire       ivEvent = selEvent && ivEn_r;
    wire [7:0] ivInc   = ivCnt_r + 8'h01;
    wire       match   = ivEvent && (ivInc == target_r);

    // Control bits; a write to the control register outranks the single-shot clear
    wire timeEn_nxt = wrCtrl ? sfrWrData[itb_pkg::CTRL_TIME_EN] : timeEn_r;
    wire ivEn_nxt   = wrCtrl ? sfrWrData[itb_pkg::CTRL_IV_EN] :
                      (match && single_r) ? 1'b0 : ivEn_r;
    wire flag_nxt   = match ? 1'b1 :
                      wrCtrl ? sfrWrData[itb_pkg::CTRL_FLAG] : flag_r;
    wire [7:0] ivCnt_nxt = !ivEn_nxt ? itb_pkg::RESET_BYTE :
                           match     ? itb_pkg::RESET_BYTE :
                           ivEvent   ? ivInc : ivCnt_r;

    // Read mux; reserved control bits and unmapped addresses read zero
    wire [7:0] ctrlView = {2'b00, tbSel_r, single_r, flag_r, ivEn_r, timeEn_r};
    wire [7:0] rd_nxt   = (sfrAddr == itb_pkg::ADDR_CTRL)   ? ctrlView :
                          (sfrAddr == itb_pkg::ADDR_FRAC)   ? frac_r :
                          (sfrAddr == itb_pkg::ADDR_SEC)    ? sec_r :
                          (sfrAddr == itb_pkg::ADDR_MIN)    ? min_r :
                          (sfrAddr == itb_pkg::ADDR_HOUR)   ? hour_r :
                          (sfrAddr == itb_pkg::ADDR_TARGET) ? target_r : 8'h00;

    // Control register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timeEn_r <= 1'b0;
            ivEn_r   <= 1'b0;
            flag_r   <= 1'b0;
            single_r <= 1'b0;
            tbSel_r  <= itb_pkg::TB_FRAC;
        end else begin
            timeEn_r <= timeEn_nxt;
            ivEn_r   <= ivEn_nxt;
            flag_r   <= flag_nxt;
            if (wrCtrl) begin
                single_r <= sfrWrData[itb_pkg::CTRL_SINGLE];
                tbSel_r  <= itb_pkg::itb_tbase_t'(
                    sfrWrData[itb_pkg::CTRL_TBSEL_HI:itb_pkg::CTRL_TBSEL_LO]);
            end
        end
    end

    // Time registers, target and interval counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frac_r   <= itb_pkg::RESET_BYTE;
            sec_r    <= itb_pkg::RESET_BYTE;
            min_r    <= itb_pkg::RESET_BYTE;
            hour_r   <= itb_pkg::RESET_BYTE;
            target_r <= itb_pkg::RESET_BYTE;
            ivCnt_r  <= itb_pkg::RESET_BYTE;
            rd_r     <= itb_pkg::RESET_BYTE;
        end else begin
            frac_r   <= frac_nxt;
            sec_r    <= sec_nxt;
            min_r    <= min_nxt;
            hour_r   <= hour_nxt;
            target_r <= wrTarget ? sfrWrData : target_r;
            ivCnt_r  <= ivCnt_nxt;
            rd_r     <= rd_nxt;
        end
    end

    assign sfrRdData = rd_r;
    assign matchFlag = flag_r;

    // Checks on the documented behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_stopWrite;
        wrCtrl && timeEn_r && !sfrWrData[itb_pkg::CTRL_TIME_EN];
    endsequence
    sequence s_allClear;
        frac_r == 8'h00 && sec_r == 8'h00 && min_r == 8'h00 && hour_r == 8'h00;
    endsequence

    property p_fracHold;
        !timeEn_r && !wrFrac |=> $stable(frac_r);
    endproperty
    a_fracHold: assert property (p_fracHold) else $error("fraction moved while stopped");

    property p_fracWrap;
        fracWrap && !timeStop |=> frac_r == 8'h00 && sec_r != $past(sec_r);
    endproperty
    a_fracWrap: assert property (p_fracWrap) else $error("fraction wrap wrong");

    property p_secWrap;
        timeEn_r && !timeStop && tick && frac_r == 8'h7f && sec_r == 8'h3b
            |=> sec_r == 8'h00;
    endproperty
    a_secWrap: assert property (p_secWrap) else $error("seconds wrap wrong");

    property p_minWrap;
        secWrap && !timeStop && min_r == 8'h3b |=> min_r == 8'h00;
    endproperty
    a_minWrap: assert property (p_minWrap) else $error("minutes wrap wrong");

    property p_hourWrap;
        minWrap && !timeStop && hour_r == 8'h17 |=> hour_r == 8'h00;
    endproperty
    a_hourWrap: assert property (p_hourWrap) else $error("hours wrap wrong");

    property p_match;
        match |=> flag_r ##1 flag_r || $past(wrCtrl);
    endproperty
    a_match: assert property (p_match) else $error("match did not set flag");

    property p_sticky;
        flag_r && !wrCtrl |=> flag_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped by hardware");

    property p_single;
        match && single_r && !wrCtrl |=> !ivEn_r && ivCnt_r == 8'h00;
    endproperty
    a_single: assert property (p_single) else $error("single shot kept running");

    property p_reload;
        match && !single_r && !wrCtrl |=> ivEn_r && ivCnt_r == 8'h00;
    endproperty
    a_reload: assert property (p_reload) else $error("auto reload failed");

    property p_ivOff;
        !ivEn_r |-> ivCnt_r == 8'h00;
    endproperty
    a_ivOff: assert property (p_ivOff) else $error("interval counter not cleared");

    property p_select;
        ivEn_r && !selEvent && !wrCtrl |=> $stable(ivCnt_r);
    endproperty
    a_select: assert property (p_select) else $error("counter moved off timebase");

    property p_timeStop;
        s_stopWrite |=> s_allClear;
    endproperty
    a_timeStop: assert property (p_timeStop) else $error("time registers not cleared");

endmodule : itb_timebase

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    // Short prescaler so a 1/128 s tick is four clocks
    localparam int         TC    = 4;
    localparam logic [7:0] aCtl  = itb_pkg::ADDR_CTRL;
    localparam logic [7:0] aFrac = itb_pkg::ADDR_FRAC;
    localparam logic [7:0] aSec  = itb_pkg::ADDR_SEC;
    localparam logic [7:0] aMin  = itb_pkg::ADDR_MIN;
    localparam logic [7:0] aHour = itb_pkg::ADDR_HOUR;
    localparam logic [7:0] aTgt  = itb_pkg::ADDR_TARGET;

    logic       core_clk    = 1'b0;
    logic       sys_rst     = 1'b1;
    logic [7:0] sfrAddr     = 8'h00;
    logic       sfrWrEn     = 1'b0;
    logic [7:0] sfrWrData   = 8'h00;
    logic [7:0] sfrRdData;
    logic       matchFlag;
    int         n_mismatch  = 0;
    int         comparisons = 0;
    int         lv;

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    itb_timebase #(.TICK_CYCLES(TC)) dut (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .sfrAddr   (sfrAddr),
        .sfrWrEn   (sfrWrEn),
        .sfrWrData (sfrWrData),
        .sfrRdData (sfrRdData),
        .matchFlag (matchFlag)
    );

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfrAddr   <= a;
        sfrWrEn   <= 1'b1;
        sfrWrData <= d;
        @(posedge core_clk);
        sfrWrEn   <= 1'b0;
    endtask : wr

    // Registered read data settles one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfrAddr <= a;
        @(posedge core_clk);
        #1 chk(sfrRdData, e);
    endtask : rd

    // Flag check after a given number of edges
    task automatic fl(input int n, input logic e);
        repeat (n) @(posedge core_clk);
        #1 chk({7'h00, matchFlag}, {7'h00, e});
    endtask : fl

    task automatic results;
        $display("counts: %0d mismatches in %0d compares", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // Cut a hang short, well past the expected run length
    initial begin
        repeat (6000) @(posedge core_clk);
        n_mismatch++;
        results();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values, unmapped neighbours included
        for (int a = 'ha0; a <= 'ha7; a++) begin
            rd(8'(a), 8'h00);
        end
        wr(aTgt, 8'hff);
        rd(aTgt, 8'hff);
        $display("test reset done");
        // Preload one level short or exactly at terminal, so only the
        // selected rollover can fire a target of one on the first tick
        for (int n = 0; n < 2; n++) begin
            for (int k = n; k < 4; k++) begin
                lv = k - n;
                wr(aCtl, 8'h00);
                wr(aFrac, lv >= 1 ? itb_pkg::FRAC_MAX : 8'h00);
                wr(aSec, lv >= 2 ? itb_pkg::SEC_MAX : 8'h00);
                wr(aMin, lv >= 3 ? itb_pkg::MIN_MAX : 8'h00);
                wr(aHour, itb_pkg::HOUR_MAX);
                wr(aTgt, 8'h01);
                rd(aMin, lv >= 3 ? itb_pkg::MIN_MAX : 8'h00);
                wr(aCtl, 8'h03 | 8'(k << 4));
                fl(TC, 1'b0);
                fl(3, n == 0);
                rd(aHour, (k == 3 && n == 0) ? 8'h00 : itb_pkg::HOUR_MAX);
                rd(aCtl, 8'h03 | 8'(k << 4) | (n == 0 ? 8'h04 : 8'h00));
            end
        end
        $display("test timebase done");
        // Single shot, sticky flag, refused time write
        wr(aCtl, 8'h00);
        wr(aTgt, 8'h03);
        wr(aCtl, 8'h0b);
        fl(3 * TC, 1'b0);
        fl(3, 1'b1);
        rd(aCtl, 8'h0d);
        fl(5 * TC, 1'b1);
        wr(aSec, 8'h2a);
        rd(aSec, 8'h00);
        wr(aCtl, 8'h09);
        fl(4 * TC, 1'b0);
        $display("test single done");
        // Partial count is lost when the interval enable drops
        wr(aCtl, 8'h03);
        fl(2 * TC, 1'b0);
        wr(aCtl, 8'h01);
        wr(aCtl, 8'h03);
        fl(2 * TC, 1'b0);
        fl(TC + 2, 1'b1);
        wr(aCtl, 8'h03);
        fl(1, 1'b0);
        fl(3 * TC + 2, 1'b1);
        $display("test reload done");
        // Hold while stopped, then count from the loaded value
        wr(aCtl, 8'h00);
        wr(aCtl, 8'h00);
        wr(aFrac, 8'h10);
        repeat (3 * TC) @(posedge core_clk);
        rd(aFrac, 8'h10);
        wr(aCtl, 8'h01);
        repeat (5 * TC + 2) @(posedge core_clk);
        rd(aFrac, 8'h15);
        wr(aCtl, 8'h00);
        rd(aFrac, 8'h00);
        $display("test fraction done");
        results();
    end
endmodule : tb_top
